// file: cmrs_pkg.sv
// Purpose: shared constants and types of the core memory rmw sequencer
// Assumes: pclk at 50 MHz, memory time base of 10 MHz
// Notes: register offsets are byte addresses on a 32-bit apb
package cmrs_pkg;

  // ********************************
  // widths and timing
  // ********************************
  localparam int ADDR_W = 14;
  localparam int DATA_W = 24;
  localparam int CNT_W = 4;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 100;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] CNT_READ_END = 4'h1;
  localparam logic [CNT_W-1:0] CNT_DATA_READY = 4'h6;
  localparam logic [CNT_W-1:0] CNT_WRITE_START = 4'h7;
  localparam logic [CNT_W-1:0] CNT_USER_READY = 4'h7;
  localparam logic [CNT_W-1:0] CNT_RELEASE = 4'hf;

  // ********************************
  // register map
  // ********************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_USER_ADDR = 8'h04;
  localparam logic [7:0] REG_USER_WDATA = 8'h08;
  localparam logic [7:0] REG_USER_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_GO = 0;
  localparam int CTRL_STORE = 1;
  localparam int CTRL_CLR_PERR = 2;
  localparam int CTRL_CLR_DONE = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_PENDING = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_PERR = 3;
  localparam int STAT_AU_OWNER = 4;
  localparam int STAT_CNT_LSB = 8;

  typedef enum logic [1:0] {
    S_IDLE,
    S_PRIO,
    S_RUN
  } cmrs_state_t;

  // one when the word holds an even number of ones, giving odd parity
  function automatic logic odd_parity_bit(input logic [DATA_W-1:0] word);
    odd_parity_bit = ~(^word);
  endfunction

endpackage

// file: cmrs_timer_if.sv
// Purpose: link between sequencer and its cycle time counter
// Assumes: single pclk domain
// Notes: none
`timescale 1ns/1ns
interface cmrs_timer_if;
  logic clear;
  logic enable;
  logic tick;
  logic [cmrs_pkg::CNT_W-1:0] count;

  modport seq (output clear, output enable, input tick, input count);
  modport timer (input clear, input enable, output tick, output count);
endinterface

// file: cmrs_timer.sv
// Purpose: four-stage binary cycle time counter on a 10 MHz time base
// Assumes: pclk at 50 MHz
// Notes: tick marks the pclk edge on which the count advances
`timescale 1ns/1ns
module cmrs_timer
(
  input wire logic pclk,
  input wire logic presetn,
  cmrs_timer_if.timer tif
);

  logic [2:0] pre_q;
  logic [cmrs_pkg::CNT_W-1:0] count_q;
  logic tick_c;

  // ********************************
  // 10 MHz prescaler
  // ********************************
  assign tick_c = tif.enable && (pre_q == 3'(cmrs_pkg::TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_q <= 3'h0;
    else if (tif.clear || !tif.enable || tick_c)
      pre_q <= 3'h0;
    else
      pre_q <= pre_q + 3'h1;
  end

  // ********************************
  // binary count
  // ********************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= '0;
    else if (tif.clear)
      count_q <= '0;
    else if (tick_c)
      count_q <= count_q + 4'h1;
  end

  assign tif.tick = tick_c;
  assign tif.count = count_q;

endmodule

// file: cmrs_sequencer.sv
// Purpose: memory control sequencer, one read-modify-write cycle per request
// Assumes: apb master on pclk; module data stable by the end of count six
// Notes: software-started user accesses compete with the arithmetic unit
//
// Function
// - cycles start only from a memory request, independent of module timing
// - first clock after request resolves priority, sets grant flag and grant (here the request is synchronised first, so grant sets on the sixth clock)
// - grant drives rmw enable and steers 14-bit address to module
// - grant enables data mux passing 24-bit b register word
// - after grant, counter runs and read start goes to module
// - four-stage binary counter advances on each 10 MHz pulse
// - read start drops once the count has passed one
// - at count six data ready goes to the arithmetic unit
// - next pulse after data ready raises write start
// - at count octal 17 memory release marks cycle end
// - store and read requests run the same timed sequence
// - no new module request before previous cycle would finish
// - reads load b register from memory; stores inhibit that load
// - words read are checked for parity error
// - user stores use clear-write, user reads use read-restore (user reads here raise read start only, with no write start)
// - parity generated on every write
// - odd parity: even ones add a one bit; bad reads flag error
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ns
module cmrs_sequencer
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_memory_request,
  input wire logic cpu_store,
  input wire logic [cmrs_pkg::ADDR_W-1:0] cpu_address,
  input wire logic [cmrs_pkg::DATA_W-1:0] b_register,
  input wire logic [cmrs_pkg::DATA_W-1:0] mem_data_in,
  input wire logic mem_parity_in,
  output logic cpu_priority_grant_flag,
  output logic cpu_access_grant,
  output logic rmw_enable,
  output logic data_mux_enable,
  output logic read_start,
  output logic write_start,
  output logic data_ready_to_cpu,
  output logic memory_release,
  output logic load_b_from_memory,
  output logic [cmrs_pkg::ADDR_W-1:0] address_mux,
  output logic [cmrs_pkg::DATA_W-1:0] data_mux,
  output logic data_mux_parity,
  output logic parity_error
);

  cmrs_timer_if tif ();

  cmrs_timer u_timer
  (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif)
  );

  cmrs_pkg::cmrs_state_t state_q;
  logic [2:0] req_sync_q;
  logic req_level_q;
  logic req_armed_q;
  logic au_owner_q;
  logic store_q;
  logic user_pending_q;
  logic user_store_q;
  logic user_done_q;
  logic perr_q;
  logic [cmrs_pkg::ADDR_W-1:0] user_addr_q;
  logic [cmrs_pkg::DATA_W-1:0] user_wdata_q;
  logic [cmrs_pkg::DATA_W-1:0] user_rdata_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic grant_flag_q;
  logic grant_q;
  logic rmw_q;
  logic dmux_q;
  logic rstart_q;
  logic wstart_q;
  logic dready_q;
  logic release_q;
  logic loadb_q;
  logic [cmrs_pkg::ADDR_W-1:0] amux_q;
  logic [cmrs_pkg::DATA_W-1:0] dmux_data_q;
  logic dmux_par_q;
  logic perr_out_q;

  logic setup_c;
  logic wr_c;
  logic mapped_c;
  logic au_req_c;
  logic cycle_end_c;
  logic sample_c;
  logic read_ok_c;
  logic go_c;
  logic [cmrs_pkg::CNT_W-1:0] cnt_c;
  logic running_c;

  assign cnt_c = tif.count;
  assign running_c = (state_q == cmrs_pkg::S_RUN);
  assign cycle_end_c = running_c && tif.tick && (cnt_c == cmrs_pkg::CNT_RELEASE);
  assign sample_c = running_c && tif.tick
                    && (cnt_c == (au_owner_q ? cmrs_pkg::CNT_DATA_READY : cmrs_pkg::CNT_USER_READY));
  assign read_ok_c = (^{mem_data_in, mem_parity_in});

  // ********************************
  // apb slave
  // ********************************
  assign setup_c = psel && !penable;
  assign wr_c = psel && penable && pready_q && pwrite && !pslverr_q;
  assign go_c = wr_c && (paddr == cmrs_pkg::REG_CTRL) && pwdata[cmrs_pkg::CTRL_GO];

  always_comb
  begin
    case (paddr)
      cmrs_pkg::REG_CTRL,
      cmrs_pkg::REG_USER_ADDR,
      cmrs_pkg::REG_USER_WDATA,
      cmrs_pkg::REG_USER_RDATA,
      cmrs_pkg::REG_STATUS: mapped_c = 1'b1;
      default: mapped_c = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup_c;
      pslverr_q <= setup_c && !mapped_c;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0;
    else if (setup_c && !pwrite)
    begin
      prdata_q <= 32'h0;
      case (paddr)
        cmrs_pkg::REG_CTRL: prdata_q[cmrs_pkg::CTRL_STORE] <= user_store_q;
        cmrs_pkg::REG_USER_ADDR: prdata_q[cmrs_pkg::ADDR_W-1:0] <= user_addr_q;
        cmrs_pkg::REG_USER_WDATA: prdata_q[cmrs_pkg::DATA_W-1:0] <= user_wdata_q;
        cmrs_pkg::REG_USER_RDATA: prdata_q[cmrs_pkg::DATA_W-1:0] <= user_rdata_q;
        cmrs_pkg::REG_STATUS:
        begin
          prdata_q[cmrs_pkg::STAT_BUSY] <= (state_q != cmrs_pkg::S_IDLE);
          prdata_q[cmrs_pkg::STAT_PENDING] <= user_pending_q;
          prdata_q[cmrs_pkg::STAT_DONE] <= user_done_q;
          prdata_q[cmrs_pkg::STAT_PERR] <= perr_q;
          prdata_q[cmrs_pkg::STAT_AU_OWNER] <= au_owner_q && running_c;
          prdata_q[cmrs_pkg::STAT_CNT_LSB +: cmrs_pkg::CNT_W] <= cnt_c;
        end
        default: prdata_q <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      user_addr_q <= '0;
      user_wdata_q <= '0;
      user_store_q <= 1'b0;
    end
    else if (wr_c && !user_pending_q)
    begin
      case (paddr)
        cmrs_pkg::REG_CTRL: user_store_q <= pwdata[cmrs_pkg::CTRL_STORE];
        cmrs_pkg::REG_USER_ADDR: user_addr_q <= pwdata[cmrs_pkg::ADDR_W-1:0];
        cmrs_pkg::REG_USER_WDATA: user_wdata_q <= pwdata[cmrs_pkg::DATA_W-1:0];
        default: user_addr_q <= user_addr_q;
      endcase
    end
  end

  // ********************************
  // user request and status flags
  // ********************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      user_pending_q <= 1'b0;
    else if (go_c)
      user_pending_q <= 1'b1;
    else if (cycle_end_c && !au_owner_q)
      user_pending_q <= 1'b0;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      user_done_q <= 1'b0;
    else if (cycle_end_c && !au_owner_q)
      user_done_q <= 1'b1;
    else if (wr_c && (paddr == cmrs_pkg::REG_CTRL) && pwdata[cmrs_pkg::CTRL_CLR_DONE])
      user_done_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      perr_q <= 1'b0;
    else if (sample_c && !store_q && !read_ok_c)
      perr_q <= 1'b1;
    else if (wr_c && (paddr == cmrs_pkg::REG_CTRL) && pwdata[cmrs_pkg::CTRL_CLR_PERR])
      perr_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      user_rdata_q <= '0;
    else if (sample_c && !au_owner_q && !store_q)
      user_rdata_q <= mem_data_in;
  end

  // ********************************
  // request synchroniser
  // ********************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_sync_q <= 3'h0;
    else
      req_sync_q <= {req_sync_q[1:0], cpu_memory_request};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_level_q <= 1'b0;
    else if (req_sync_q[1] == req_sync_q[2])
      req_level_q <= req_sync_q[2];
  end

  // a request still high from the last cycle must drop before it counts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_armed_q <= 1'b1;
    else if (state_q == cmrs_pkg::S_PRIO && au_req_c && !user_pending_q)
      req_armed_q <= 1'b0;
    else if (!req_level_q)
      req_armed_q <= 1'b1;
  end

  assign au_req_c = req_level_q && req_armed_q;

  // ********************************
  // sequencer state
  // ********************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= cmrs_pkg::S_IDLE;
    else
    begin
      case (state_q)
        cmrs_pkg::S_IDLE:
          if (au_req_c || user_pending_q)
            state_q <= cmrs_pkg::S_PRIO;
        cmrs_pkg::S_PRIO:
          state_q <= cmrs_pkg::S_RUN;
        cmrs_pkg::S_RUN:
          if (cycle_end_c)
            state_q <= cmrs_pkg::S_IDLE;
        default: state_q <= cmrs_pkg::S_IDLE;
      endcase
    end
  end

  // user accesses take precedence over the unit when both wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      au_owner_q <= 1'b0;
      store_q <= 1'b0;
    end
    else if (state_q == cmrs_pkg::S_PRIO)
    begin
      au_owner_q <= !user_pending_q;
      store_q <= user_pending_q ? user_store_q : cpu_store;
    end
  end

  assign tif.enable = running_c;
  assign tif.clear = !running_c || cycle_end_c;

  // ********************************
  // module and unit controls
  // ********************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      grant_flag_q <= 1'b0;
      grant_q <= 1'b0;
      rmw_q <= 1'b0;
      dmux_q <= 1'b0;
    end
    else if (state_q == cmrs_pkg::S_PRIO && !user_pending_q)
    begin
      grant_flag_q <= 1'b1;
      grant_q <= 1'b1;
      rmw_q <= 1'b1;
      dmux_q <= 1'b1;
    end
    else if (cycle_end_c || !running_c)
    begin
      grant_flag_q <= 1'b0;
      grant_q <= 1'b0;
      rmw_q <= 1'b0;
      dmux_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rstart_q <= 1'b0;
      wstart_q <= 1'b0;
      dready_q <= 1'b0;
      release_q <= 1'b0;
      loadb_q <= 1'b0;
    end
    else
    begin
      if (au_owner_q)
      begin
        rstart_q <= running_c && !cycle_end_c && (cnt_c <= cmrs_pkg::CNT_READ_END);
        wstart_q <= running_c && (cnt_c == cmrs_pkg::CNT_WRITE_START);
        dready_q <= running_c && !cycle_end_c && (cnt_c >= cmrs_pkg::CNT_DATA_READY);
        release_q <= running_c && !cycle_end_c && (cnt_c == cmrs_pkg::CNT_RELEASE);
        loadb_q <= sample_c && !store_q;
      end
      else
      begin
        rstart_q <= running_c && !store_q && (cnt_c <= cmrs_pkg::CNT_READ_END);
        wstart_q <= running_c && store_q && (cnt_c <= cmrs_pkg::CNT_READ_END);
        dready_q <= 1'b0;
        release_q <= 1'b0;
        loadb_q <= 1'b0;
      end
    end
  end

  // ********************************
  // address and data multiplexers
  // ********************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      amux_q <= '0;
      dmux_data_q <= '0;
      dmux_par_q <= 1'b0;
    end
    else if (running_c ? au_owner_q : (state_q == cmrs_pkg::S_PRIO && !user_pending_q))
    begin
      amux_q <= cpu_address;
      dmux_data_q <= b_register;
      dmux_par_q <= cmrs_pkg::odd_parity_bit(b_register);
    end
    else if (running_c)
    begin
      amux_q <= user_addr_q;
      dmux_data_q <= user_wdata_q;
      dmux_par_q <= cmrs_pkg::odd_parity_bit(user_wdata_q);
    end
    else
    begin
      amux_q <= '0;
      dmux_data_q <= '0;
      dmux_par_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      perr_out_q <= 1'b0;
    else if (sample_c)
      perr_out_q <= !store_q && !read_ok_c;
    else if (!running_c)
      perr_out_q <= 1'b0;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cpu_priority_grant_flag = grant_flag_q;
  assign cpu_access_grant = grant_q;
  assign rmw_enable = rmw_q;
  assign data_mux_enable = dmux_q;
  assign read_start = rstart_q;
  assign write_start = wstart_q;
  assign data_ready_to_cpu = dready_q;
  assign memory_release = release_q;
  assign load_b_from_memory = loadb_q;
  assign address_mux = amux_q;
  assign data_mux = dmux_data_q;
  assign data_mux_parity = dmux_par_q;
  assign parity_error = perr_out_q;

endmodule

// file: cmrs_sequencer_asserts.sv
// Purpose: port timing checks of the sequencer
// Assumes: single pclk domain
// Notes: bound to cmrs_sequencer
`timescale 1ns/1ns
module cmrs_asserts
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_memory_request,
  input wire logic cpu_store,
  input wire logic [cmrs_pkg::ADDR_W-1:0] cpu_address,
  input wire logic cpu_priority_grant_flag,
  input wire logic cpu_access_grant,
  input wire logic rmw_enable,
  input wire logic data_mux_enable,
  input wire logic read_start,
  input wire logic write_start,
  input wire logic data_ready_to_cpu,
  input wire logic memory_release,
  input wire logic load_b_from_memory,
  input wire logic [cmrs_pkg::ADDR_W-1:0] address_mux,
  input wire logic [cmrs_pkg::DATA_W-1:0] data_mux,
  input wire logic data_mux_parity
);
  logic [4:0] rs_n_q;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****************
  // read start length
  // ****************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rs_n_q <= 5'h00;
    else if (read_start)
      rs_n_q <= rs_n_q + 5'h01;
    else
      rs_n_q <= 5'h00;
  end
  req_cause_a:
  assert property ($rose(cpu_access_grant) |-> $past(cpu_memory_request, 4)) else $error("grant without request");
  grant_set_a:
  assert property (cpu_access_grant |-> cpu_priority_grant_flag && rmw_enable && data_mux_enable)
    else $error("grant without enables");
  addr_mux_a:
  assert property (cpu_access_grant && $past(cpu_access_grant) |-> address_mux == $past(cpu_address))
    else $error("address not steered");
  par_gen_a:
  assert property (data_mux_enable |-> data_mux_parity == ~^data_mux) else $error("bad write parity");
  rd_first_a:
  assert property ($rose(cpu_access_grant) |-> ##1 $rose(read_start)) else $error("read start late");
  rd_len_a:
  assert property ($fell(read_start) |-> rs_n_q == 5'h0a) else $error("read start length");
  dr_time_a:
  assert property ($rose(cpu_access_grant) |-> ##31 $rose(data_ready_to_cpu)) else $error("data ready time");
  ws_next_a:
  assert property ($rose(data_ready_to_cpu) |-> ##5 $rose(write_start) ##1 write_start[*4] ##1 !write_start)
    else $error("write start timing");
  rel_time_a:
  assert property ($rose(cpu_access_grant) |-> ##76 $rose(memory_release) ##1 memory_release[*3]
    ##1 !memory_release && !cpu_access_grant) else $error("release timing");
  dr_hold_a:
  assert property (data_ready_to_cpu |-> cpu_access_grant) else $error("data ready outside cycle");
  load_b_a:
  assert property (load_b_from_memory |-> data_ready_to_cpu && !cpu_store ##1 !load_b_from_memory)
    else $error("b load misplaced");
  apb_rdy_a:
  assert property (psel && penable |-> pready ##1 !pready) else $error("apb ready timing");
  cover property ($rose(load_b_from_memory));
  cover property ($rose(write_start) && cpu_store);
  cover property (pready && pslverr);
endmodule
bind cmrs_sequencer cmrs_asserts u_cmrs_asserts (.*);

// file: cmrs_mem_model.sv
// Purpose: core memory module stand-in
// Assumes: one word plus parity bit per address
// Notes: from the end of a write until the next read start the data lines show inverted data
`timescale 1ns/1ns
module cmrs_mem_model
(
  input wire logic pclk,
  input wire logic read_start,
  input wire logic write_start,
  input wire logic bad_parity,
  input wire logic [cmrs_pkg::ADDR_W-1:0] address_mux,
  input wire logic [cmrs_pkg::DATA_W-1:0] data_mux,
  input wire logic data_mux_parity,
  output logic [cmrs_pkg::DATA_W-1:0] mem_data_in,
  output logic mem_parity_in
);
  logic [24:0] core_q [16384];
  logic [24:0] dr_q;
  logic rs_q;
  logic ws_q;
  logic ok_q;
  initial
  begin
    for (int i = 0; i < 16384; i++)
      core_q[i] = 25'h1000000;
    dr_q = 25'h0000000;
    rs_q = 1'b0;
    ws_q = 1'b0;
    ok_q = 1'b0;
  end
  always @(posedge pclk)
  begin
    rs_q <= read_start;
    ws_q <= write_start;
    if (read_start && !rs_q)
    begin
      dr_q <= core_q[address_mux];
      ok_q <= 1'b1;
    end
    if (ws_q && !write_start)
    begin
      core_q[address_mux] <= {data_mux_parity, data_mux};
      ok_q <= 1'b0;
    end
  end
  assign mem_data_in = ok_q ? dr_q[23:0] : ~dr_q[23:0];
  assign mem_parity_in = (ok_q ? dr_q[24] : ~dr_q[24]) ^ bad_parity;
endmodule

// file: tb_top.sv
// Purpose: self-checking bench of the rmw sequencer
// Assumes: bench plays the arithmetic unit and apb master
// Notes: memory side is cmrs_mem_model
`timescale 1ns/1ns
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic cpu_memory_request, cpu_store, mem_parity_in, bad_parity;
  logic [cmrs_pkg::ADDR_W-1:0] cpu_address, address_mux;
  logic [cmrs_pkg::DATA_W-1:0] b_register, mem_data_in, data_mux;
  logic cpu_priority_grant_flag, cpu_access_grant, rmw_enable, data_mux_enable;
  logic read_start, write_start, data_ready_to_cpu, memory_release;
  logic load_b_from_memory, data_mux_parity, parity_error;
  int miscompares, n_checks, cyc;
  cmrs_sequencer u_cmrs_sequencer (.*);
  cmrs_mem_model u_cmrs_mem_model (.*);
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("pslverr", 32'(err), 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    apb(1'b0, a, 32'h0);
    chk("prdata", rdv, exp);
    chk("pslverr", 32'(err), 32'(ee));
  endtask
  task automatic poll();
    int n;
    n = 0;
    rdv = 32'h0;
    while (rdv[cmrs_pkg::STAT_DONE] !== 1'b1 && n < 100)
    begin
      apb(1'b0, cmrs_pkg::REG_STATUS, 32'h0);
      n++;
    end
    chk("status_done", 32'(rdv[cmrs_pkg::STAT_DONE]), 32'h1);
  endtask
  task automatic au(input logic st, input logic [13:0] a, input logic [23:0] b, input logic pe);
    int n;
    int lb;
    n = 0;
    lb = 0;
    cpu_store <= st;
    cpu_address <= a;
    b_register <= b;
    cpu_memory_request <= 1'b1;
    while (memory_release !== 1'b1 && n < 300)
    begin
      @(posedge pclk);
      n++;
      if (load_b_from_memory === 1'b1)
      begin
        lb++;
        chk("b_load_word", 32'(mem_data_in), 32'(b));
      end
    end
    chk("release", 32'(memory_release), 32'h1);
    chk("data_ready", 32'(data_ready_to_cpu), 32'h1);
    chk("address_mux", 32'(address_mux), 32'(a));
    chk("data_mux", 32'(data_mux), 32'(b));
    chk("dmux_parity", 32'(data_mux_parity), 32'(~^b));
    chk("parity_error", 32'(parity_error), 32'(pe));
    chk("b_load_count", 32'(lb), 32'(!st));
    repeat (20) @(posedge pclk);
    chk("regrant", 32'(cpu_access_grant), 32'h0);
    chk("release_end", 32'(memory_release), 32'h0);
    cpu_memory_request <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpu_memory_request = 1'b0;
    cpu_store = 1'b0;
    cpu_address = 14'h0000;
    b_register = 24'h000000;
    bad_parity = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("grant", 32'(cpu_access_grant), 32'h0);
    chk("read_start", 32'(read_start), 32'h0);
    $display("test reset done");
    au(1'b1, 14'h3fff, 24'h000003, 1'b0);
    au(1'b0, 14'h3fff, 24'h000003, 1'b0);
    au(1'b1, 14'h0000, 24'h000001, 1'b0);
    bad_parity <= 1'b1;
    au(1'b0, 14'h0000, 24'h000001, 1'b1);
    bad_parity <= 1'b0;
    $display("test unit cycles done");
    wr(cmrs_pkg::REG_USER_ADDR, 32'h00000155);
    wr(cmrs_pkg::REG_USER_WDATA, 32'h005a5a5a);
    wr(cmrs_pkg::REG_CTRL, 32'h00000003);
    poll();
    wr(cmrs_pkg::REG_CTRL, 32'h00000008);
    wr(cmrs_pkg::REG_CTRL, 32'h00000001);
    poll();
    rd(cmrs_pkg::REG_USER_RDATA, 32'h005a5a5a, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    au(1'b0, 14'h0155, 24'h5a5a5a, 1'b0);
    $display("test user access done");
    tally_and_finish();
  end
endmodule
